// ===== hdl/pcm_pwm_consts.svh
// timing counts and widths for the peak current mode pwm block
`ifndef PCM_PWM_CONSTS_SVH
`define PCM_PWM_CONSTS_SVH

`define CLK_PERIOD_NS      25
`define DEAD_TIME_NS       100
`define DEAD_CYCLES        ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PERIOD_CYCLES      400
`define CNT_W              16
`define DATA_W             12
`define ERR_W              14
`define KP_SHIFT           2
`define KI_SHIFT           6
`define INTEG_W            20
`define DEMAND_RST         12'h0000
`define DEMAND_MAX         12'h0fff

`endif

// ===== hdl/pcm_pwm_pkg.sv
// types for the peak current mode pwm block
package pcm_pwm_pkg;
	typedef enum logic [3:0] {
		ST_IDLE     = 4'b0001,
		ST_HIGH_ON  = 4'b0010,
		ST_DEAD_LOW = 4'b0100,
		ST_LOW_ON   = 4'b1000
	} phase_t;
endpackage

// ===== hdl/demand_compensator.sv
// pi compensator turning output voltage error into a demand peak current
`timescale 1ns/10ps
`default_nettype none
`include "pcm_pwm_consts.svh"
module demand_compensator
	import pcm_pwm_pkg::*;
(
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rstn_i,
	// once per period update strobe
	input  wire logic                 update_i,
	// measured output and setpoint
	input  wire logic [`DATA_W-1:0]   vout_i,
	input  wire logic [`DATA_W-1:0]   vref_i,
	// demand peak current, registered
	output logic      [`DATA_W-1:0]   demand_o
);
	logic signed [`ERR_W-1:0]   err;
	logic signed [`INTEG_W-1:0] integ_ff;
	logic signed [`INTEG_W-1:0] nxt_integ;
	logic signed [`INTEG_W-1:0] sum;

	// -------------------------------------------------------------
	// error and control law
	// -------------------------------------------------------------
	always_comb begin
		err = $signed({2'b00, vref_i}) - $signed({2'b00, vout_i});
		nxt_integ = integ_ff + `INTEG_W'(err);
		// clamp the integrator so it cannot wind past the output range
		if (nxt_integ < 0) begin
			nxt_integ = '0;
		end else if (nxt_integ > (`INTEG_W'(`DEMAND_MAX) <<< `KI_SHIFT)) begin
			nxt_integ = `INTEG_W'(`DEMAND_MAX) <<< `KI_SHIFT;
		end
		sum = (nxt_integ >>> `KI_SHIFT) + (`INTEG_W'(err) <<< `KP_SHIFT);
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			integ_ff <= '0;
		end else if (update_i) begin
			integ_ff <= nxt_integ;
		end
	end

	// -------------------------------------------------------------
	// demand output, updated once per switching cycle
	// -------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			demand_o <= `DEMAND_RST;
		end else if (update_i) begin
			if (sum < 0) begin
				demand_o <= `DEMAND_RST;
			end else if (sum > `INTEG_W'(`DEMAND_MAX)) begin
				demand_o <= `DEMAND_MAX;
			end else begin
				demand_o <= sum[`DATA_W-1:0];
			end
		end
	end
endmodule
`default_nettype wire

// ===== hdl/peak_current_mode_pwm.sv
// peak current mode pwm: clocked set, comparator reset, dead-time
`timescale 1ns/10ps
`default_nettype none
`include "pcm_pwm_consts.svh"
// Operation
// - period start: high side on, low off
// - on-interval end drops high side output
// - dead-time keeps both switches never on together
// - low side only after full dead-time
// - period pulse sets latch, no fixed on-time
// - current reaching demand resets the latch
// - demand from compensator, or from demand_ext_i when follow_i is set, updated each cycle
// - compensator error from vout and setpoint
// - duty set by current rise time, capped at max duty by force_off
// - at most one turn-off per cycle
// - shared demand output for paralleled stages
module peak_current_mode_pwm
	import pcm_pwm_pkg::*;
(
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rstn_i,
	// enable from the system (pin)
	input  wire logic                 enable_i,
	// sensed inductor current and voltage measurements
	input  wire logic [`DATA_W-1:0]   isense_i,
	input  wire logic [`DATA_W-1:0]   vout_i,
	input  wire logic [`DATA_W-1:0]   vref_i,
	// external demand for follower stages
	input  wire logic                 follow_i,
	input  wire logic [`DATA_W-1:0]   demand_ext_i,
	// gate drive outputs
	output logic                      high_side_switch_o,
	output logic                      low_side_switch_o,
	// status and shared demand
	output logic [`DATA_W-1:0]        demand_o,
	output logic                      period_pulse_o,
	output logic                      peak_trip_o
);
	localparam logic [`CNT_W-1:0] PERIOD_LAST = `CNT_W'(`PERIOD_CYCLES - 1);
	localparam logic [`CNT_W-1:0] DEAD_LAST   = `CNT_W'(`DEAD_CYCLES - 1);
	// count at which the low side turns off, DEAD_CYCLES before the period rolls over
	localparam logic [`CNT_W-1:0] LOW_OFF_AT  =
		`CNT_W'(`PERIOD_CYCLES - 1 - `DEAD_CYCLES);

	// -------------------------------------------------------------
	// input synchronisers
	// -------------------------------------------------------------
	logic                en_s1_ff;
	logic                en_s2_ff;
	logic                fol_s1_ff;
	logic                fol_s2_ff;
	logic [`DATA_W-1:0]  is_s1_ff;
	logic [`DATA_W-1:0]  is_s2_ff;
	logic [`DATA_W-1:0]  vo_s1_ff;
	logic [`DATA_W-1:0]  vo_s2_ff;
	logic [`DATA_W-1:0]  vr_s1_ff;
	logic [`DATA_W-1:0]  vr_s2_ff;
	logic [`DATA_W-1:0]  de_s1_ff;
	logic [`DATA_W-1:0]  de_s2_ff;

	// multi-bit samples may tear for one cycle; the converter values
	// move slowly relative to the clock so a one sample glitch is benign
	// one block per input; only the second stage is read downstream
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			en_s1_ff  <= 1'b0;
			en_s2_ff  <= 1'b0;
		end else begin
			en_s1_ff  <= enable_i;
			en_s2_ff  <= en_s1_ff;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			fol_s1_ff <= 1'b0;
			fol_s2_ff <= 1'b0;
		end else begin
			fol_s1_ff <= follow_i;
			fol_s2_ff <= fol_s1_ff;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			is_s1_ff  <= '0;
			is_s2_ff  <= '0;
		end else begin
			is_s1_ff  <= isense_i;
			is_s2_ff  <= is_s1_ff;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			vo_s1_ff  <= '0;
			vo_s2_ff  <= '0;
		end else begin
			vo_s1_ff  <= vout_i;
			vo_s2_ff  <= vo_s1_ff;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			vr_s1_ff  <= '0;
			vr_s2_ff  <= '0;
		end else begin
			vr_s1_ff  <= vref_i;
			vr_s2_ff  <= vr_s1_ff;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			de_s1_ff  <= '0;
			de_s2_ff  <= '0;
		end else begin
			de_s1_ff  <= demand_ext_i;
			de_s2_ff  <= de_s1_ff;
		end
	end

	// -------------------------------------------------------------
	// switching period counter and clock pulse
	// -------------------------------------------------------------
	logic [`CNT_W-1:0] period_cnt_ff;
	logic              period_start;

	assign period_start = en_s2_ff && (period_cnt_ff == PERIOD_LAST);

	always_ff @(posedge clk_i) begin
		if (!rstn_i || !en_s2_ff) begin
			period_cnt_ff <= '0;
		end else if (period_cnt_ff == PERIOD_LAST) begin
			period_cnt_ff <= '0;
		end else begin
			period_cnt_ff <= period_cnt_ff + `CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			period_pulse_o <= 1'b0;
		end else begin
			period_pulse_o <= period_start;
		end
	end

	// -------------------------------------------------------------
	// compensator and demand selection
	// -------------------------------------------------------------
	logic [`DATA_W-1:0] comp_demand;
	logic [`DATA_W-1:0] demand_ff;

	demand_compensator u_comp (
		.clk_i    (clk_i),
		.rstn_i   (rstn_i),
		.update_i (period_start),
		.vout_i   (vo_s2_ff),
		.vref_i   (vr_s2_ff),
		.demand_o (comp_demand)
	);

	// demand is latched at period start so it holds through the cycle
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			demand_ff <= `DEMAND_RST;
		end else if (period_start) begin
			demand_ff <= fol_s2_ff ? de_s2_ff : comp_demand;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			demand_o <= `DEMAND_RST;
		end else begin
			demand_o <= comp_demand;
		end
	end

	// -------------------------------------------------------------
	// set-reset latch and phase sequencer
	// -------------------------------------------------------------
	phase_t            phase_ff;
	logic [`CNT_W-1:0] dead_cnt_ff;
	logic              tripped_ff;
	logic              peak_hit;
	logic              trip_now;
	logic              force_off;
	logic              dead_done;

	// comparison runs every cycle, trip_now uses it only while the high side conducts; no on-time target
	assign peak_hit = (is_s2_ff >= demand_ff);

	// -------------------------------------------------------------
	// comparator accept and period limits
	// -------------------------------------------------------------
	// a hit counts only once the gate is on: the synced current still
	// shows the last period, so an early hit would skip the on-time
	assign trip_now = (phase_ff == ST_HIGH_ON) && high_side_switch_o &&
		peak_hit && !tripped_ff;

	// max duty: both gates off early enough for the dead-time to fit
	assign force_off = (period_cnt_ff == LOW_OFF_AT);

	// last dead-time count: low side may switch on at this edge
	assign dead_done = (dead_cnt_ff == DEAD_LAST);

	always_ff @(posedge clk_i) begin
		if (!rstn_i || !en_s2_ff) begin
			phase_ff <= ST_IDLE;
		end else begin
			case (phase_ff)
				ST_IDLE: begin
					if (period_start) begin
						phase_ff <= ST_HIGH_ON;
					end
				end
				ST_HIGH_ON: begin
					if (force_off) begin
						// max duty: force off so dead-time fits
						phase_ff <= ST_IDLE;
					end else if (trip_now) begin
						phase_ff <= ST_DEAD_LOW;
					end
				end
				ST_DEAD_LOW: begin
					if (force_off) begin
						phase_ff <= ST_IDLE;
					end else if (dead_done) begin
						phase_ff <= ST_LOW_ON;
					end
				end
				ST_LOW_ON: begin
					if (force_off) begin
						phase_ff <= ST_IDLE;
					end
				end
				default: begin
					phase_ff <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i || phase_ff != ST_DEAD_LOW) begin
			dead_cnt_ff <= '0;
		end else begin
			dead_cnt_ff <= dead_cnt_ff + `CNT_W'(1);
		end
	end

	// one turn-off per cycle; cleared only by the next clock pulse
	always_ff @(posedge clk_i) begin
		if (!rstn_i || period_start) begin
			tripped_ff <= 1'b0;
		end else if (trip_now) begin
			tripped_ff <= 1'b1;
		end
	end

	// -------------------------------------------------------------
	// gate drive outputs
	// -------------------------------------------------------------
	// a cut period from enable going low leaves both gates off
	always_ff @(posedge clk_i) begin
		if (!rstn_i || !en_s2_ff) begin
			high_side_switch_o <= 1'b0;
		end else begin
			high_side_switch_o <= (phase_ff == ST_HIGH_ON) &&
				!trip_now && !force_off;
		end
	end

	// low side waits out the dead count; force_off wins so the next
	// period's high side always sees a full gap
	always_ff @(posedge clk_i) begin
		if (!rstn_i || !en_s2_ff) begin
			low_side_switch_o <= 1'b0;
		end else begin
			low_side_switch_o <= ((phase_ff == ST_LOW_ON) ||
				(phase_ff == ST_DEAD_LOW && dead_done)) &&
				!force_off;
		end
	end

	// forced turn-off at max duty is not reported as a trip
	always_ff @(posedge clk_i) begin
		if (!rstn_i || !en_s2_ff) begin
			peak_trip_o <= 1'b0;
		end else begin
			peak_trip_o <= trip_now && !force_off;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/pcm_pwm_assertions.sv
// checker for the gate drive timing of the peak current mode pwm
`timescale 1ns/10ps
`default_nettype none
`include "pcm_pwm_consts.svh"
module pcm_pwm_assertions (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic enable_i,
	input wire logic high_side_switch_o,
	input wire logic low_side_switch_o,
	input wire logic period_pulse_o,
	input wire logic peak_trip_o
);
	// ----------------------------------------------------------------
	// helpers: cycles since pulse, trip seen in this period
	// ----------------------------------------------------------------
	logic [15:0] cnt_ff;
	logic        first_ff;
	logic        trip_ff;
	always_ff @(posedge clk_i) begin
		if (!rstn_i || !enable_i || period_pulse_o)
			cnt_ff <= 16'h0000;
		else
			cnt_ff <= cnt_ff + 16'h0001;
	end
	always_ff @(posedge clk_i) begin
		if (!rstn_i || !enable_i)
			first_ff <= 1'b1;
		else if (period_pulse_o)
			first_ff <= 1'b0;
	end
	always_ff @(posedge clk_i) begin
		if (!rstn_i || period_pulse_o)
			trip_ff <= 1'b0;
		else if (peak_trip_o)
			trip_ff <= 1'b1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	AST_NO_OVERLAP: assert property (
		!(high_side_switch_o && low_side_switch_o)) else $error("both on");
	AST_DEAD_HL: assert property (
		$fell(high_side_switch_o) |-> !low_side_switch_o [*4])
		else $error("low side inside dead time");
	AST_DEAD_LH: assert property (
		$fell(low_side_switch_o) |-> !high_side_switch_o [*4])
		else $error("high side inside dead time");
	AST_PULSE_HIGH: assert property (
		period_pulse_o |=> high_side_switch_o && !low_side_switch_o)
		else $error("period start without high side");
	AST_HS_CAUSE: assert property (
		$rose(high_side_switch_o) |-> $past(period_pulse_o))
		else $error("high side on without pulse");
	AST_TRIP_DROP: assert property (
		peak_trip_o |-> !high_side_switch_o && $past(high_side_switch_o))
		else $error("trip without high side turn-off");
	AST_ONE_TRIP: assert property (
		peak_trip_o |-> !trip_ff) else $error("second trip in a period");
	AST_PERIOD: assert property (
		period_pulse_o && !first_ff |-> cnt_ff == `PERIOD_CYCLES - 1)
		else $error("period length wrong");
	cover property (peak_trip_o);
	cover property ($fell(low_side_switch_o));
	cover property (period_pulse_o && !first_ff);
endmodule
`default_nettype wire

// ===== testbench/buck_stage_model.sv
// inductor current as seen behind the gate drivers of the switch pair
`timescale 1ns/10ps
`default_nettype none
`include "pcm_pwm_consts.svh"
module buck_stage_model (
	input  wire logic              clk_i,
	input  wire logic              high_side_switch_i,
	input  wire logic              low_side_switch_i,
	output logic [`DATA_W-1:0]     isense_o
);
	// coarse slopes so a period sweeps a wide range; saturates at top
	initial isense_o = '0;
	always @(posedge clk_i) begin
		if (high_side_switch_i && isense_o < 12'h0ff8)
			isense_o <= #2 isense_o + 12'h0008;
		else if (low_side_switch_i && isense_o > 12'h000f)
			isense_o <= #2 isense_o - 12'h0010;
		else if (low_side_switch_i)
			isense_o <= #2 '0;
	end
endmodule
`default_nettype wire

// ===== testbench/peak_current_mode_pwm_tb.sv
// self-checking bench for the peak current mode pwm block
`timescale 1ns/10ps
`default_nettype none
`include "pcm_pwm_consts.svh"
module peak_current_mode_pwm_tb;
	logic               clk_i, rstn_i, enable_i, follow_i, hs, ls, pls, trp;
	logic [`DATA_W-1:0] isense, vout, vref, dext, demand, got;
	logic               arm;
	logic [`DATA_W-1:0] exp_q[$];
	int                 n_fail, checked, cyc;
	peak_current_mode_pwm DUT (.clk_i(clk_i), .rstn_i(rstn_i),
		.enable_i(enable_i), .isense_i(isense), .vout_i(vout),
		.vref_i(vref), .follow_i(follow_i), .demand_ext_i(dext),
		.high_side_switch_o(hs), .low_side_switch_o(ls),
		.demand_o(demand), .period_pulse_o(pls), .peak_trip_o(trp));
	buck_stage_model stage (.clk_i(clk_i), .high_side_switch_i(hs),
		.low_side_switch_i(ls), .isense_o(isense));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// ----------------------------------------------------------------
	// reporting
	// ----------------------------------------------------------------
	task automatic check(input logic ok, input string msg);
		checked++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	task automatic close_out;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// whole run is about 17 periods, ceiling leaves ample slack
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 12000) begin
			n_fail++;
			close_out();
		end
	end
	// ----------------------------------------------------------------
	// monitor: each trip consumes the demand noted for its period
	// ----------------------------------------------------------------
	always @(negedge clk_i) begin
		if (trp === 1'b1 && arm) begin
			if (exp_q.size() == 0)
				check(1'b0, "trip with nothing noted");
			else begin
				got = exp_q.pop_front();
				check(isense >= got && isense < got + 12'h0040, "on-time");
			end
		end
	end
	// ----------------------------------------------------------------
	// stimulus
	// ----------------------------------------------------------------
	task automatic wait_pulses(input int n);
		repeat (n) @(posedge pls);
		@(posedge clk_i);
		#2;
	endtask
	task automatic next_demand;
		@(negedge hs);
		@(posedge clk_i);
		#2;
		dext = 12'h0064 + 12'($urandom % 1400);
		exp_q.push_back(dext);
	endtask
	initial begin
		void'($urandom(32'h384d_05ee));
		{rstn_i, enable_i, follow_i, arm} = 4'b0000;
		{n_fail, checked, cyc} = '0;
		vout = 12'h0fff;
		vref = 12'h0000;
		dext = 12'h0010;
		repeat (12) @(posedge clk_i);
		#2;
		rstn_i = 1'b1;
		enable_i = 1'b1;
		wait_pulses(3);
		check(demand === 12'h0000, "demand not clamped low");
		vout = 12'h0000;
		vref = 12'h0fff;
		wait_pulses(3);
		check(demand === 12'h0fff, "demand not clamped high");
		// first follower period trips at once on the leftover current;
		// its long low side phase drains the stage back to zero
		follow_i = 1'b1;
		wait_pulses(1);
		@(negedge hs);
		@(posedge clk_i);
		#2;
		arm = 1'b1;
		exp_q.push_back(dext);
		repeat (8) next_demand();
		wait_pulses(2);
		check(exp_q.size() == 0, "periods without trip");
		close_out();
	end
endmodule
bind peak_current_mode_pwm pcm_pwm_assertions chk (.clk_i(clk_i),
	.rstn_i(rstn_i), .enable_i(enable_i),
	.high_side_switch_o(high_side_switch_o),
	.low_side_switch_o(low_side_switch_o),
	.period_pulse_o(period_pulse_o), .peak_trip_o(peak_trip_o));
`default_nettype wire
